//--- dv/lvx_link_partner.sv
// Link partner: reference clocks and the far end of the serial line
`default_nettype none
module lvx_link_partner (
  input wire logic tx_run,
  input wire logic rx_run,
  input wire logic tx_serial,
  output logic tx_ref_clk,
  output logic rx_ref_clk,
  output logic rx_serial
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // Reference clocks
  // ----------------
  // A stopped clock stands low, so lock loss can be provoked
  initial begin
    tx_ref_clk = 1'b0;
    forever #62.5 tx_ref_clk = tx_run & ~tx_ref_clk;
  end
  initial begin
    rx_ref_clk = 1'b0;
    #17;
    forever #62.5 rx_ref_clk = rx_run & ~rx_ref_clk;
  end
  // Echo lets one stream exercise both directions
  assign #3 rx_serial = tx_serial;
endmodule
`default_nettype wire

//--- dv/lvx_serdes_top_asserts.sv
// Checker: port properties of the serial link top
`default_nettype none
module lvx_serdes_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic pll_areset,
  input wire logic tx_serial,
  input wire logic tx_fwd_clk,
  input wire logic tx_core_clk,
  input wire logic tx_lock,
  input wire logic rx_out_clk,
  input wire logic rx_lock
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Properties
  // ----------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  a_apb_wait: assert property (s_setup |=> s_answer)
    else $error("pready not in second access cycle");
  a_pready_one: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  a_areset_clear: assert property (pll_areset |=>
    !tx_lock && !rx_lock && !tx_serial && !tx_fwd_clk && !tx_core_clk)
    else $error("link outputs not cleared");
  a_lock_late: assert property ($fell(pll_areset) |-> !tx_lock [*8])
    else $error("lock too soon after reset");
  a_core_locked: assert property (tx_core_clk |-> tx_lock)
    else $error("core clock without lock");
  a_rxclk_locked: assert property (rx_out_clk |-> rx_lock)
    else $error("receive clock without lock");
  a_serial_hold: assert property (disable iff (!presetn || pll_areset)
    $changed(tx_serial) |=> $stable(tx_serial) [*7])
    else $error("serial bit too short");
endmodule
`default_nettype wire

//--- dv/lvx_serdes_top_tb.sv
// Testbench: registers, transmit words, forwarded clock, slip and lock
`default_nettype none
module lvx_serdes_top_tb
  import lvx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pll_areset, tx_load_en;
  logic tx_serial, tx_fwd_clk, tx_core_clk, tx_lock, tx_ref_clk, tx_run, core_q, fwd_q;
  logic rx_serial, rx_bitslip, rx_out_clk, rx_lock, rx_ref_clk, rx_run, mon_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [DATA_W-1:0] tx_par_in, rx_par_out, w, w0;
  logic [DATA_W-1:0] exp_q[$];
  logic [15:0] tc[4] = '{16'h40aa, 16'h41a3, 16'h40a0, 16'h41af};
  int n_fail, check_count, rat, per, mn, mk, o, o0, p;
  int seed = 32'h612e;
  wire core_up = tx_core_clk && !core_q;
  wire fwd_up = tx_fwd_clk && !fwd_q;

  lvx_serdes_top dut_u (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .pll_areset, .tx_ref_clk, .tx_par_in, .tx_load_en, .tx_serial,
    .tx_fwd_clk, .tx_core_clk, .tx_lock, .rx_ref_clk, .rx_serial, .rx_bitslip,
    .rx_par_out, .rx_out_clk, .rx_lock
  );
  lvx_link_partner peer_u (
    .tx_run, .rx_run, .tx_serial, .tx_ref_clk, .rx_ref_clk, .rx_serial
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    core_q <= tx_core_clk;
    fwd_q <= tx_fwd_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a slave that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    chk(pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk(e, xe);
  endtask

  task automatic rise(input logic s, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!(s ? fwd_up : core_up) && n < 400);
  endtask

  // Reset around the write so no bit is cut short by a mode change
  task automatic cfg(input logic [15:0] c);
    int n;
    n = 0;
    pll_areset <= 1'b1;
    wreg(OFF_CTRL, {16'h0, c});
    chk(tx_lock, 1'b0);
    pll_areset <= 1'b0;
    while (!(tx_lock === 1'b1 && rx_lock === 1'b1) && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk({tx_lock, rx_lock}, 2'b11);
    rat = c[3:0] == 0 ? 1 : (c[3:0] > 10 ? 10 : c[3:0]);
    per = c[8] ? 8 : 16;
  endtask

  task automatic tx_words(input int nw);
    logic [DATA_W-1:0] v;
    int n;
    for (int k = 0; k <= nw; k++) begin
      rise(1'b0, n);
      if (k < nw) begin
        v = DATA_W'($random(seed));
        tx_par_in <= v;
        exp_q.push_back(v & DATA_W'((1 << rat) - 1));
        mon_en <= 1'b1;
      end
    end
    repeat (per * 11) @(posedge pclk);
    chk(exp_q.size(), 0);
    mon_en <= 1'b0;
  endtask

  task automatic slip();
    rx_bitslip <= 1'b1;
    repeat (4) @(posedge pclk);
    rx_bitslip <= 1'b0;
    repeat (400) @(posedge pclk);
  endtask

  always begin
    rise(1'b0, mk);
    if (mon_en && exp_q.size() > 0) begin
      repeat (per / 2) @(posedge pclk);
      for (int i = 0; i < rat; i++) begin
        w = {w[DATA_W-2:0], tx_serial};
        if (i < rat - 1)
          repeat (per) @(posedge pclk);
      end
      chk(w & DATA_W'((1 << rat) - 1), exp_q.pop_front());
    end
  end

  initial begin
    #300us;
    n_fail++;
    close_out();
  end

  // ---------
  // Scenarios
  // ---------
  initial begin
    {presetn, psel, penable, pwrite, pll_areset, tx_load_en, rx_bitslip, mon_en} = '0;
    {tx_run, rx_run} = 2'b11;
    paddr = '0;
    pwdata = '0;
    tx_par_in = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rreg(OFF_CTRL, 32'h0000_40aa, 1'b0);
    rreg(OFF_STATUS, 32'h0, 1'b0);
    rreg(8'h0c, 32'h0, 1'b1);
    wreg(8'h0c, 32'hffff_ffff);
    wreg(OFF_STATUS, 32'hffff_ffff);
    wreg(OFF_CTRL, 32'hffff_40aa);
    rreg(OFF_CTRL, 32'h0000_40aa, 1'b0);
    cfg(16'h40aa);
    rreg(OFF_STATUS, 32'h3, 1'b0);
    foreach (tc[i]) begin
      cfg(tc[i]);
      tx_words(3);
    end
    for (int d = 0; d < 4; d++) begin
      cfg(16'h40aa | 16'(d << 9));
      rise(1'b0, mn);
      rise(1'b1, o);
      rise(1'b1, p);
      chk(p, 16 << (d > 2 ? 2 : d));
    end
    for (int k = 0; k < 8; k++) begin
      cfg(16'h40aa | 16'(k << 11));
      rise(1'b0, mn);
      rise(1'b1, o);
      if (k == 0)
        o0 = o;
      chk((o + 2 * k) % 16, o0 % 16);
    end
    cfg(16'hc0aa);
    tx_load_en <= 1'b1;
    rise(1'b0, mn);
    tx_load_en <= 1'b0;
    chk(mn, 400);
    // Word reaches the line only through the load strobe here
    cfg(16'hc0aa);
    w0 = DATA_W'($random(seed));
    tx_par_in <= w0;
    tx_load_en <= 1'b1;
    repeat (400) @(posedge pclk);
    tx_load_en <= 1'b0;
    for (int i = 0; i < 10 && rx_par_out !== w0; i++)
      slip();
    rreg(OFF_RXDATA, {22'h0, w0}, 1'b0);
    slip();
    rreg(OFF_RXDATA, {22'h0, w0[8:0], w0[9]}, 1'b0);
    chk(rx_par_out, {w0[8:0], w0[9]});
    @(posedge rx_out_clk);
    p = int'($time);
    @(posedge rx_out_clk);
    chk(32'(int'($time) - p), 10 * 16 * CLK_PERIOD_NS);
    rx_run <= 1'b0;
    repeat (200) @(posedge pclk);
    chk(rx_lock, 1'b1);
    wreg(OFF_CTRL, 32'h0000_00aa);
    repeat (200) @(posedge pclk);
    chk({tx_lock, rx_lock}, 2'b10);
    rx_run <= 1'b1;
    cfg(16'h00aa);
    close_out();
  end
endmodule

bind lvx_serdes_top lvx_serdes_chk chk_u (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata, .pll_areset,
  .tx_serial, .tx_fwd_clk, .tx_core_clk, .tx_lock, .rx_out_clk, .rx_lock
);
`default_nettype wire

//--- logic/lvx_deser.sv
// Receive deserializer with word-boundary slip
`default_nettype none
module lvx_deser
  import lvx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  lvx_pll_if.dst pll,
  input wire logic [3:0] ratio,
  input wire logic ddr,
  input wire logic bit_in,
  input wire logic slip,
  output logic [DATA_W-1:0] word,
  output logic out_clk
);
  logic [DATA_W-1:0] sh_r, sh_nxt, word_r, word_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic pend_r, pend_nxt, oclk_r, oclk_nxt;
  logic stb;

  assign stb = bit_hit(pll.phase, ddr, 1'b1);
  assign word = word_r;
  assign out_clk = oclk_r;

  always_comb begin
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    word_nxt = word_r;
    pend_nxt = pend_r | slip;
    if (!pll.locked) begin
      sh_nxt = '0;
      cnt_nxt = 4'h0;
    end else if (stb) begin
      if (pend_r) begin
        // Swallowing one bit moves the boundary; a new slip in this cycle still counts
        pend_nxt = slip;
      end else begin
        sh_nxt = {sh_r[DATA_W-2:0], bit_in};
        if (cnt_r >= ratio - 4'h1) begin
          word_nxt = {sh_r[DATA_W-2:0], bit_in} & ratio_mask(ratio);
          cnt_nxt = 4'h0;
        end else begin
          cnt_nxt = cnt_r + 4'h1;
        end
      end
    end
    oclk_nxt = pll.locked & ({cnt_nxt, 1'b0} < {1'b0, ratio});
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_r <= '0;
      cnt_r <= 4'h0;
      word_r <= '0;
      pend_r <= 1'b0;
      oclk_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      word_r <= word_nxt;
      pend_r <= pend_nxt;
      oclk_r <= oclk_nxt;
    end
  end
endmodule
`default_nettype wire

//--- logic/lvx_pkg.sv
// Package: constants, register map and helpers of the serial link interface
`default_nettype none
package lvx_pkg;
  // ---------------------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------------------
  localparam int DATA_W = 10;
  localparam int PH_W = 6;
  localparam int CLK_PERIOD_NS = 4;
  localparam int PLL_RST_MIN_NS = 10;
  localparam int PLL_RST_MIN_CYC = (PLL_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] LOCK_EDGES = 4'h8;
  localparam logic [7:0] REF_TIMEOUT = 8'h40;
  localparam logic [3:0] RATIO_MAX = 4'ha;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RXDATA = 8'h08;
  localparam int CTRL_SER_LSB = 0;
  localparam int CTRL_DES_LSB = 4;
  localparam int CTRL_DDR_BIT = 8;
  localparam int CTRL_DIV_LSB = 9;
  localparam int CTRL_PHASE_LSB = 11;
  localparam int CTRL_SHARE_BIT = 14;
  localparam int CTRL_EXT_BIT = 15;
  localparam int STAT_TXLOCK_BIT = 0;
  localparam int STAT_RXLOCK_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_40aa;
  localparam logic [15:0] CTRL_WMASK = 16'hffff;

  typedef enum logic [2:0] {
    LVX_ST_IDLE = 3'b001,
    LVX_ST_ACQ = 3'b010,
    LVX_ST_LOCK = 3'b100
  } lvx_pll_st_e;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [3:0] ratio_clamp(input logic [3:0] r);
    if (r == 4'h0) return 4'h1;
    if (r > RATIO_MAX) return RATIO_MAX;
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] ratio_mask(input logic [3:0] r);
    logic [DATA_W:0] one;
    one = {{DATA_W{1'b0}}, 1'b1};
    return DATA_W'((one << r) - one);
  endfunction

  // Bit boundary (mid=0) or bit centre (mid=1) on the serial phase count
  function automatic logic bit_hit(input logic [PH_W-1:0] ph, input logic ddr,
                                   input logic mid);
    if (ddr) return ph[2:0] == {mid, 2'h0};
    return ph[3:0] == {mid, 3'h0};
  endfunction
endpackage
`default_nettype wire

//--- logic/lvx_pll.sv
// Clock multiplier model: locks to a reference clock and runs the serial phase count
`default_nettype none
module lvx_pll
  import lvx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ref_clk,
  lvx_pll_if.src pll
);
  logic ref1_r, ref2_r, ref3_r;
  lvx_pll_st_e st_r, st_nxt;
  logic [3:0] edges_r, edges_nxt;
  logic [7:0] idle_r, idle_nxt;
  logic [PH_W-1:0] ph_r, ph_nxt;
  logic lock_r, lock_nxt;
  logic ref_edge;

  assign ref_edge = ref2_r & ~ref3_r;
  assign pll.locked = lock_r;
  assign pll.phase = ph_r;

  always_comb begin
    st_nxt = st_r;
    edges_nxt = edges_r;
    idle_nxt = ref_edge ? 8'h00 : idle_r + 8'h01;
    case (st_r)
      LVX_ST_IDLE: begin
        edges_nxt = 4'h0;
        if (ref_edge) begin
          st_nxt = LVX_ST_ACQ;
          edges_nxt = 4'h1;
        end
      end
      LVX_ST_ACQ: begin
        if (ref_edge) edges_nxt = edges_r + 4'h1;
        if (edges_nxt >= LOCK_EDGES) st_nxt = LVX_ST_LOCK;
        if (idle_r >= REF_TIMEOUT) st_nxt = LVX_ST_IDLE;
      end
      LVX_ST_LOCK: begin
        // A stalled reference drops lock rather than running on a stale rate
        if (idle_r >= REF_TIMEOUT) st_nxt = LVX_ST_IDLE;
      end
      default: st_nxt = LVX_ST_IDLE;
    endcase
    if (idle_r >= REF_TIMEOUT) idle_nxt = 8'h00;
    lock_nxt = st_nxt == LVX_ST_LOCK;
    ph_nxt = lock_nxt ? ph_r + 6'h01 : 6'h00;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref1_r <= 1'b0;
      ref2_r <= 1'b0;
      ref3_r <= 1'b0;
      st_r <= LVX_ST_IDLE;
      edges_r <= 4'h0;
      idle_r <= 8'h00;
      ph_r <= 6'h00;
      lock_r <= 1'b0;
    end else begin
      ref1_r <= ref_clk;
      ref2_r <= ref1_r;
      ref3_r <= ref2_r;
      st_r <= st_nxt;
      edges_r <= edges_nxt;
      idle_r <= idle_nxt;
      ph_r <= ph_nxt;
      lock_r <= lock_nxt;
    end
  end
endmodule
`default_nettype wire

//--- logic/lvx_pll_if.sv
// Interface: lock flag and serial phase count of one clock multiplier
`default_nettype none
interface lvx_pll_if;
  import lvx_pkg::*;
  logic locked;
  logic [PH_W-1:0] phase;
  modport src(output locked, output phase);
  modport dst(input locked, input phase);
endinterface
`default_nettype wire

//--- logic/lvx_serdes_top.sv
// Top: serial link transmitter, receiver, clock multipliers and APB registers
`default_nettype none
// Function
// - SDR one bit, DDR two bits per serial clock
// - Parallel words at most ten bits wide
// - Multiplier reset is asynchronous, held 10 ns; the code only retimes its release by two pclk cycles (8 ns)
// - Word width equals serialization ratio
// - Serial output timed by multiplier serial clock
// - Forwarded clock at rate, half or quarter
// - Forwarded clock phase in 45 degree steps
// - Core clock output paces fabric transmit words; held low with external multiplier
// - Transmit lock high while multiplier locked
// - One shared multiplier or one per direction
// - Receive word width equals deserialization ratio
// - Bit slip rising edge shifts boundary one
// - Receive lock high while its multiplier locked
// - Multiplier reset and controls are active high; presetn is active low
module lvx_serdes_top
  import lvx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pll_areset,
  input wire logic tx_ref_clk,
  input wire logic [DATA_W-1:0] tx_par_in,
  input wire logic tx_load_en,
  output logic tx_serial,
  output logic tx_fwd_clk,
  output logic tx_core_clk,
  output logic tx_lock,
  input wire logic rx_ref_clk,
  input wire logic rx_serial,
  input wire logic rx_bitslip,
  output logic [DATA_W-1:0] rx_par_out,
  output logic rx_out_clk,
  output logic rx_lock
);
  // ---------------------------------------------------------------------------
  // Multiplier reset
  // ---------------------------------------------------------------------------
  logic arst_n, prst1_r, prst_n_r;

  // Asserts at once with no clock; release is retimed to keep recovery clean
  assign arst_n = presetn & ~pll_areset;

  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      prst1_r <= 1'b0;
      prst_n_r <= 1'b0;
    end else begin
      prst1_r <= 1'b1;
      prst_n_r <= prst1_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  localparam int SYN_W = DATA_W + 3;
  logic [SYN_W-1:0] syn1_r, syn2_r;
  logic load3_r, slip3_r;
  logic [DATA_W-1:0] par_s;
  logic load_s, rx_s, slip_s, load_edge, slip_edge;

  assign par_s = syn2_r[SYN_W-1:3];
  assign load_s = syn2_r[2];
  assign rx_s = syn2_r[1];
  assign slip_s = syn2_r[0];
  assign load_edge = load_s & ~load3_r;
  assign slip_edge = slip_s & ~slip3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      syn1_r <= '0;
      syn2_r <= '0;
      load3_r <= 1'b0;
      slip3_r <= 1'b0;
    end else begin
      syn1_r <= {tx_par_in, tx_load_en, rx_serial, rx_bitslip};
      syn2_r <= syn1_r;
      load3_r <= load_s;
      slip3_r <= slip_s;
    end
  end

  // ---------------------------------------------------------------------------
  // APB registers
  // ---------------------------------------------------------------------------
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [31:0] prdata_r, prdata_nxt, rd_val;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic rd_hit, acc_wait, acc_done;
  logic txlk_r, txlk_nxt;

  assign acc_wait = psel & penable & ~pready_r;
  assign acc_done = psel & penable & pready_r;

  always_comb begin
    rd_hit = 1'b1;
    case (paddr)
      OFF_CTRL: rd_val = {16'h0000, ctrl_r};
      OFF_STATUS: rd_val = {30'h0, rx_lock, txlk_r};
      OFF_RXDATA: rd_val = {22'h0, rx_par_out};
      default: begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
    ctrl_nxt = ctrl_r;
    if (acc_done && pwrite && paddr == OFF_CTRL) ctrl_nxt = pwdata[15:0] & CTRL_WMASK;
    // One wait state: data and status settle before pready is shown
    pready_nxt = acc_wait;
    prdata_nxt = (acc_wait && !pwrite) ? rd_val : 32'h0000_0000;
    pslverr_nxt = acc_wait & ~rd_hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET[15:0];
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ---------------------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------------------
  logic [3:0] ser_ratio, des_ratio;
  logic [1:0] div_sel, sh_amt;
  logic [2:0] phase_sel;
  logic ddr, share, ext_pll;

  assign ser_ratio = ratio_clamp(ctrl_r[CTRL_SER_LSB +: 4]);
  assign des_ratio = ratio_clamp(ctrl_r[CTRL_DES_LSB +: 4]);
  assign ddr = ctrl_r[CTRL_DDR_BIT];
  assign div_sel = (ctrl_r[CTRL_DIV_LSB +: 2] == 2'h3) ? 2'h2 : ctrl_r[CTRL_DIV_LSB +: 2];
  assign phase_sel = ctrl_r[CTRL_PHASE_LSB +: 3];
  assign share = ctrl_r[CTRL_SHARE_BIT];
  assign ext_pll = ctrl_r[CTRL_EXT_BIT];
  // Forwarded period is 8 phase steps of (1 << sh_amt) cycles each
  assign sh_amt = div_sel + {1'b0, ~ddr};

  // ---------------------------------------------------------------------------
  // Clock multipliers
  // ---------------------------------------------------------------------------
  lvx_pll_if tx_pll_if();
  lvx_pll_if rx_pll_if();
  lvx_pll_if rx_sel_if();

  lvx_pll u_tx_pll (
    .clk(pclk),
    .rst_n(prst_n_r),
    .ref_clk(tx_ref_clk),
    .pll(tx_pll_if.src)
  );

  lvx_pll u_rx_pll (
    .clk(pclk),
    .rst_n(prst_n_r),
    .ref_clk(rx_ref_clk),
    .pll(rx_pll_if.src)
  );

  // Sharing hands the receiver the transmit multiplier; otherwise its own
  assign rx_sel_if.locked = share ? tx_pll_if.locked : rx_pll_if.locked;
  assign rx_sel_if.phase = share ? tx_pll_if.phase : rx_pll_if.phase;

  // ---------------------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------------------
  lvx_deser u_deser (
    .clk(pclk),
    .rst_n(prst_n_r),
    .pll(rx_sel_if.dst),
    .ratio(des_ratio),
    .ddr(ddr),
    .bit_in(rx_s),
    .slip(slip_edge),
    .word(rx_par_out),
    .out_clk(rx_out_clk)
  );

  logic rxlk_r;

  always_ff @(posedge pclk or negedge prst_n_r) begin
    if (!prst_n_r) begin
      rxlk_r <= 1'b0;
    end else begin
      rxlk_r <= rx_sel_if.locked;
    end
  end

  assign rx_lock = rxlk_r;

  // ---------------------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] sh_r, sh_nxt, word_r, word_nxt, src;
  logic [3:0] cnt_r, cnt_nxt;
  logic ser_r, ser_nxt, fwd_r, fwd_nxt, core_r, core_nxt;
  logic [PH_W-1:0] ph, pos;
  logic locked, bit_stb, half;

  assign locked = tx_pll_if.locked;
  assign ph = tx_pll_if.phase;
  assign bit_stb = bit_hit(ph, ddr, 1'b0);
  assign half = ddr ? ph[2] : ph[3];
  assign pos = ph + PH_W'({3'b000, phase_sel} << sh_amt);
  // Without the external multiplier, fabric data is read at the word boundary
  assign src = ext_pll ? word_r : par_s;

  always_comb begin
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    ser_nxt = ser_r;
    word_nxt = word_r;
    if (ext_pll && load_edge) word_nxt = par_s;
    if (!locked) begin
      sh_nxt = '0;
      cnt_nxt = 4'h0;
      ser_nxt = 1'b0;
    end else if (bit_stb) begin
      if (cnt_r == 4'h0) begin
        sh_nxt = src & ratio_mask(ser_ratio);
        ser_nxt = src[ser_ratio - 4'h1];
        cnt_nxt = ser_ratio - 4'h1;
      end else begin
        ser_nxt = sh_r[cnt_r - 4'h1];
        cnt_nxt = cnt_r - 4'h1;
      end
    end
    // Three-bit index: a two-bit sum would wrap the quarter-rate tap onto bit 0 or 1
    fwd_nxt = locked & pos[{1'b0, sh_amt} + 3'h2];
    if (ser_ratio == 4'h1) begin
      core_nxt = ~half;
    end else begin
      core_nxt = {cnt_r, 1'b0} >= {1'b0, ser_ratio};
    end
    core_nxt = core_nxt & locked & ~ext_pll;
    txlk_nxt = locked;
  end

  always_ff @(posedge pclk or negedge prst_n_r) begin
    if (!prst_n_r) begin
      sh_r <= '0;
      cnt_r <= 4'h0;
      ser_r <= 1'b0;
      fwd_r <= 1'b0;
      core_r <= 1'b0;
      word_r <= '0;
      txlk_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      ser_r <= ser_nxt;
      fwd_r <= fwd_nxt;
      core_r <= core_nxt;
      word_r <= word_nxt;
      txlk_r <= txlk_nxt;
    end
  end

  assign tx_serial = ser_r;
  assign tx_fwd_clk = fwd_r;
  assign tx_core_clk = core_r;
  assign tx_lock = txlk_r;
endmodule
`default_nettype wire
